/* hw/lvic_ctrl.sv */
// Leveled vector interrupt controller: request capture, masking, ranking, vector answer
//
// Implementation choices: the register offsets and the address-and-strobe port.
`default_nettype none
module lvic_ctrl (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // External pins
   input wire logic emulation_request_in_n_i,
   input wire logic ext_request_six_i,
   input wire logic pen_request_in_i,
   input wire logic ext_request_three_i,
   input wire logic ext_request_two_i,
   input wire logic ext_request_one_i,
   input wire logic [3:0] gp_request_i,
   // Internal peripheral requests, level, same clock
   input wire logic brkpt_req_i,
   input wire logic tmr1_req_i,
   input wire logic tmr2_req_i,
   input wire logic pwm1_req_i,
   input wire logic pwm2_req_i,
   input wire logic spi1_req_i,
   input wire logic spi2_req_i,
   input wire logic uart1_req_i,
   input wire logic uart2_req_i,
   input wire logic wdt_req_i,
   input wire logic rtc_req_i,
   input wire logic rti_req_i,
   input wire logic kbd_req_i,
   // CPU side
   input wire logic vector_fetch_cycle_i,
   input wire logic [2:0] ack_level_i,
   output logic [2:0] level_o,
   output logic [7:0] vector_o,
   output logic vector_valid_o
);
   localparam int NSRC = lvic_pkg::NSRC;
   localparam int NPIN = lvic_pkg::NPIN;

   // Clamp of a programmed level into 0..6
   function automatic logic [2:0] prog_clamp(input logic [2:0] v);
      return (v == lvic_pkg::LVL_TOP) ? lvic_pkg::LVL_MAX_PROG : v;
   endfunction : prog_clamp

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [4:0] vec_base_r;
   logic vec_init_r;
   logic [15:0] pin_trig_r;
   logic [7:0] gp_trig_r;
   logic [NSRC-1:0] mask_r;
   logic [11:0] prog_lvl_r;
   logic [NSRC-1:0] status_r;
   logic [NSRC-1:0] status_nxt;
   logic [NPIN-1:0] sync1_r;
   logic [NPIN-1:0] sync2_r;
   logic [NPIN-1:0] assert_prev_r;
   logic [2:0] level_r;
   logic [7:0] vector_r;
   logic vector_valid_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_vec = reg_wr_i && (reg_addr_i == lvic_pkg::OFS_VECTOR_BASE);
   wire wr_trig = reg_wr_i && (reg_addr_i == lvic_pkg::OFS_PIN_TRIGGER);
   wire wr_gp = reg_wr_i && (reg_addr_i == lvic_pkg::OFS_GP_TRIGGER);
   wire wr_mask = reg_wr_i && (reg_addr_i == lvic_pkg::OFS_MASK);
   wire wr_stat = reg_wr_i && (reg_addr_i == lvic_pkg::OFS_REQ_STATUS);
   wire wr_prog = reg_wr_i && (reg_addr_i == lvic_pkg::OFS_PROG_LEVEL);
   wire [NSRC-1:0] w1c = wr_stat ? reg_wdata_i[NSRC-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and trigger decode
   wire [NPIN-1:0] pins_raw = {emulation_request_in_n_i, pen_request_in_i, gp_request_i,
                               ext_request_one_i, ext_request_two_i, ext_request_three_i,
                               ext_request_six_i};
   wire [NPIN-1:0] pin_pol = {1'b0, pin_trig_r[lvic_pkg::POL5_BIT],
                              gp_trig_r[lvic_pkg::GP_POL_LSB +: 4],
                              pin_trig_r[lvic_pkg::POL1_BIT], pin_trig_r[lvic_pkg::POL2_BIT],
                              pin_trig_r[lvic_pkg::POL3_BIT], pin_trig_r[lvic_pkg::POL6_BIT]};
   wire [NPIN-1:0] pin_et = {2'b00, gp_trig_r[lvic_pkg::GP_ET_LSB +: 4],
                             pin_trig_r[lvic_pkg::ET1_BIT], pin_trig_r[lvic_pkg::ET2_BIT],
                             pin_trig_r[lvic_pkg::ET3_BIT], pin_trig_r[lvic_pkg::ET6_BIT]};
   // Polarity 0 means active low
   wire [NPIN-1:0] pin_assert = ~(sync2_r ^ pin_pol);
   wire [NPIN-1:0] pin_edge = pin_assert & ~assert_prev_r;

   ////////////////////////////////////////////////////////////////////////////
   // Request vectors per source
   logic [NSRC-1:0] raw_req;
   logic [NSRC-1:0] edge_set;
   logic [NSRC-1:0] edge_mode;

   always_comb begin
      raw_req = '0;
      edge_set = '0;
      edge_mode = '0;
      raw_req[lvic_pkg::SRC_EMU] = pin_assert[lvic_pkg::PIN_EMU];
      raw_req[lvic_pkg::SRC_BRK] = brkpt_req_i;
      raw_req[lvic_pkg::SRC_TMR1] = tmr1_req_i;
      raw_req[lvic_pkg::SRC_PWM1] = pwm1_req_i;
      raw_req[lvic_pkg::SRC_TMR2] = tmr2_req_i;
      raw_req[lvic_pkg::SRC_PWM2] = pwm2_req_i;
      raw_req[lvic_pkg::SRC_SPI1] = spi1_req_i;
      raw_req[lvic_pkg::SRC_UART2] = uart2_req_i;
      raw_req[lvic_pkg::SRC_PEN] = pin_assert[lvic_pkg::PIN_PEN];
      raw_req[lvic_pkg::SRC_SPI2] = spi2_req_i;
      raw_req[lvic_pkg::SRC_UART1] = uart1_req_i;
      raw_req[lvic_pkg::SRC_WDT] = wdt_req_i;
      raw_req[lvic_pkg::SRC_RTC] = rtc_req_i;
      raw_req[lvic_pkg::SRC_RTI] = rti_req_i;
      raw_req[lvic_pkg::SRC_KBD] = kbd_req_i;
      raw_req[lvic_pkg::SRC_EXT6] = pin_assert[lvic_pkg::PIN_EXT6];
      raw_req[lvic_pkg::SRC_EXT3] = pin_assert[lvic_pkg::PIN_EXT3];
      raw_req[lvic_pkg::SRC_EXT2] = pin_assert[lvic_pkg::PIN_EXT2];
      raw_req[lvic_pkg::SRC_EXT1] = pin_assert[lvic_pkg::PIN_EXT1];
      raw_req[lvic_pkg::SRC_GP0 +: 4] = pin_assert[lvic_pkg::PIN_GP0 +: 4];
      edge_set[lvic_pkg::SRC_EXT6] = pin_edge[lvic_pkg::PIN_EXT6];
      edge_set[lvic_pkg::SRC_EXT3] = pin_edge[lvic_pkg::PIN_EXT3];
      edge_set[lvic_pkg::SRC_EXT2] = pin_edge[lvic_pkg::PIN_EXT2];
      edge_set[lvic_pkg::SRC_EXT1] = pin_edge[lvic_pkg::PIN_EXT1];
      edge_set[lvic_pkg::SRC_GP0 +: 4] = pin_edge[lvic_pkg::PIN_GP0 +: 4];
      edge_mode[lvic_pkg::SRC_EXT6] = pin_et[lvic_pkg::PIN_EXT6];
      edge_mode[lvic_pkg::SRC_EXT3] = pin_et[lvic_pkg::PIN_EXT3];
      edge_mode[lvic_pkg::SRC_EXT2] = pin_et[lvic_pkg::PIN_EXT2];
      edge_mode[lvic_pkg::SRC_EXT1] = pin_et[lvic_pkg::PIN_EXT1];
      edge_mode[lvic_pkg::SRC_GP0 +: 4] = pin_et[lvic_pkg::PIN_GP0 +: 4];
   end

   // Edge bits: set wins over clear; level bits follow the source
   assign status_nxt = (edge_mode & ((status_r & ~w1c) | edge_set)) | (~edge_mode & raw_req);

   ////////////////////////////////////////////////////////////////////////////
   // Level of each source and ranking
   logic [2:0] src_lvl [NSRC];
   wire [NSRC-1:0] active = status_r & ~mask_r;
   logic [6:0] lvl_req;
   logic [2:0] top_lvl;

   genvar gi;
   genvar gl;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         if (gi >= lvic_pkg::SRC_PROG0 && gi < lvic_pkg::SRC_PROG0 + lvic_pkg::NPROG) begin : g_prog
            assign src_lvl[gi] = prog_clamp(prog_lvl_r[(gi - lvic_pkg::SRC_PROG0) * 3 +: 3]);
         end else begin : g_fix
            assign src_lvl[gi] = lvic_pkg::fixed_level(gi);
         end
      end
      for (gl = 1; gl <= 7; gl++) begin : g_lvl
         logic [NSRC-1:0] hit;
         for (gi = 0; gi < NSRC; gi++) begin : g_hit
            assign hit[gi] = active[gi] && (src_lvl[gi] == 3'(gl));
         end
         assign lvl_req[gl-1] = |hit;
      end
   endgenerate

   lvic_prio_enc u_enc (
      .lvl_req_i(lvl_req),
      .lvl_o(top_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Vector formation
   wire [7:0] ack_vector = vec_init_r ? {vec_base_r, ack_level_i} : lvic_pkg::UNINIT_VECTOR;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            lvic_pkg::OFS_VECTOR_BASE: rdata_nxt[7:0] = {vec_base_r, 3'h0};
            lvic_pkg::OFS_PIN_TRIGGER: rdata_nxt[15:0] = pin_trig_r;
            lvic_pkg::OFS_GP_TRIGGER: rdata_nxt[7:0] = gp_trig_r;
            lvic_pkg::OFS_MASK: rdata_nxt[NSRC-1:0] = mask_r;
            lvic_pkg::OFS_REQ_STATUS: rdata_nxt[NSRC-1:0] = status_r & ~mask_r;
            lvic_pkg::OFS_PENDING: rdata_nxt[NSRC-1:0] = status_r;
            lvic_pkg::OFS_PROG_LEVEL: rdata_nxt[11:0] = prog_lvl_r;
            lvic_pkg::OFS_CUR_LEVEL: rdata_nxt[2:0] = level_r;
            default: rdata_nxt = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         vec_base_r <= lvic_pkg::VEC_BASE_RST;
         vec_init_r <= 1'b0;
      end else if (wr_vec) begin
         vec_base_r <= reg_wdata_i[lvic_pkg::VEC_BASE_LSB +: lvic_pkg::VEC_BASE_W];
         vec_init_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pin_trig_r <= lvic_pkg::TRIG_RST;
      end else if (wr_trig) begin
         pin_trig_r <= {reg_wdata_i[15:7], 7'h00};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         gp_trig_r <= lvic_pkg::GP_TRIG_RST;
      end else if (wr_gp) begin
         gp_trig_r <= reg_wdata_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mask_r <= lvic_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_r <= reg_wdata_i[NSRC-1:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prog_lvl_r <= lvic_pkg::PROG_LVL_RST;
      end else if (wr_prog) begin
         prog_lvl_r <= reg_wdata_i[11:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and status
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync1_r <= lvic_pkg::PIN_IDLE;
         sync2_r <= lvic_pkg::PIN_IDLE;
         assert_prev_r <= '0;
         status_r <= '0;
      end else begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
         assert_prev_r <= pin_assert;
         status_r <= status_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU side outputs
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         level_r <= lvic_pkg::LVL_NONE;
         vector_r <= 8'h00;
         vector_valid_r <= 1'b0;
      end else begin
         level_r <= top_lvl;
         vector_valid_r <= vector_fetch_cycle_i;
         if (vector_fetch_cycle_i) begin
            vector_r <= ack_vector;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h00000000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign level_o = level_r;
   assign vector_o = vector_r;
   assign vector_valid_o = vector_valid_r;
   assign reg_rdata_o = rdata_r;
endmodule : lvic_ctrl
`default_nettype wire

/* hw/lvic_pkg.sv */
// Constants, register map and source table of the leveled vector interrupt controller
`default_nettype none
package lvic_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;
   localparam int LVL_W = 3;
   localparam int NSRC = 23;
   localparam int NPIN = 10;
   localparam int NPROG = 4;
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (word index)
   localparam logic [3:0] OFS_VECTOR_BASE = 4'h0;
   localparam logic [3:0] OFS_PIN_TRIGGER = 4'h1;
   localparam logic [3:0] OFS_GP_TRIGGER = 4'h2;
   localparam logic [3:0] OFS_MASK = 4'h3;
   localparam logic [3:0] OFS_REQ_STATUS = 4'h4;
   localparam logic [3:0] OFS_PENDING = 4'h5;
   localparam logic [3:0] OFS_PROG_LEVEL = 4'h6;
   localparam logic [3:0] OFS_CUR_LEVEL = 4'h7;
   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int VEC_BASE_LSB = 3;
   localparam int VEC_BASE_W = 5;
   localparam int TRIG_W = 16;
   localparam int POL1_BIT = 15;
   localparam int POL2_BIT = 14;
   localparam int POL3_BIT = 13;
   localparam int POL6_BIT = 12;
   localparam int ET1_BIT = 11;
   localparam int ET2_BIT = 10;
   localparam int ET3_BIT = 9;
   localparam int ET6_BIT = 8;
   localparam int POL5_BIT = 7;
   localparam int GP_ET_LSB = 0;
   localparam int GP_POL_LSB = 4;
   localparam int GP_TRIG_W = 8;
   localparam int PROG_LVL_W = NPROG * LVL_W;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed codes
   localparam logic [15:0] TRIG_RST = 16'h0000;
   localparam logic [7:0] GP_TRIG_RST = 8'h00;
   localparam logic [22:0] MASK_RST = 23'h7FFFFF;
   localparam logic [11:0] PROG_LVL_RST = 12'hDB6;
   localparam logic [4:0] VEC_BASE_RST = 5'h00;
   localparam logic [7:0] UNINIT_VECTOR = 8'h0F;
   localparam logic [2:0] LVL_NONE = 3'h0;
   localparam logic [2:0] LVL_MAX_PROG = 3'h6;
   localparam logic [2:0] LVL_TOP = 3'h7;
   localparam logic [9:0] PIN_IDLE = 10'h3FF;
   ////////////////////////////////////////////////////////////////////////////
   // Source indices
   localparam int SRC_EMU = 0;
   localparam int SRC_BRK = 1;
   localparam int SRC_EXT6 = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_PWM1 = 4;
   localparam int SRC_TMR2 = 5;
   localparam int SRC_PWM2 = 6;
   localparam int SRC_SPI1 = 7;
   localparam int SRC_UART2 = 8;
   localparam int SRC_PEN = 9;
   localparam int SRC_SPI2 = 10;
   localparam int SRC_UART1 = 11;
   localparam int SRC_WDT = 12;
   localparam int SRC_RTC = 13;
   localparam int SRC_RTI = 14;
   localparam int SRC_KBD = 15;
   localparam int SRC_GP0 = 16;
   localparam int SRC_EXT3 = 20;
   localparam int SRC_EXT2 = 21;
   localparam int SRC_EXT1 = 22;
   localparam int SRC_PROG0 = SRC_TMR2;
   // Pin indices in the synchroniser
   localparam int PIN_EXT6 = 0;
   localparam int PIN_EXT3 = 1;
   localparam int PIN_EXT2 = 2;
   localparam int PIN_EXT1 = 3;
   localparam int PIN_GP0 = 4;
   localparam int PIN_PEN = 8;
   localparam int PIN_EMU = 9;
   localparam int NEDGE_PIN = 8;

   // Fixed level of each source; programmable ones return none
   function automatic logic [2:0] fixed_level(input int idx);
      if (idx <= SRC_BRK) begin
         return 3'h7;
      end else if (idx <= SRC_PWM1) begin
         return 3'h6;
      end else if (idx <= SRC_UART2) begin
         return 3'h0;
      end else if (idx == SRC_PEN) begin
         return 3'h5;
      end else if (idx < SRC_EXT3) begin
         return 3'h4;
      end else if (idx == SRC_EXT3) begin
         return 3'h3;
      end else if (idx == SRC_EXT2) begin
         return 3'h2;
      end else begin
         return 3'h1;
      end
   endfunction : fixed_level
endpackage : lvic_pkg
`default_nettype wire

/* hw/lvic_prio_enc.sv */
// Highest-level encoder over the seven request levels
`default_nettype none
module lvic_prio_enc (
   input wire logic [6:0] lvl_req_i,
   output logic [2:0] lvl_o
);
   logic [2:0] enc;

   always_comb begin
      enc = lvic_pkg::LVL_NONE;
      for (int l = 0; l < 7; l++) begin
         if (lvl_req_i[l]) begin
            enc = 3'(l + 1);
         end
      end
   end

   assign lvl_o = enc;
endmodule : lvic_prio_enc
`default_nettype wire

/* tb/lvic_cpu_model.sv */
// Processor model answering presented levels with acknowledge cycles
`default_nettype none
module lvic_cpu_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] level_i,
   input wire logic [2:0] ipm_i,
   input wire logic [1:0] stall_i,
   input wire logic [7:0] vector_i,
   input wire logic vector_valid_i,
   input wire logic bus_err_i,
   output logic vector_fetch_cycle_o,
   output logic [2:0] ack_level_o
);
   logic [2:0] mask_r;
   logic [1:0] wait_r;
   logic busy_r;
   logic [9:0] handler_r;
   wire logic take = (level_i != 3'h0) && (level_i > mask_r);
   always_ff @(posedge sys_clk_i) begin
      vector_fetch_cycle_o <= 1'b0;
      if (!rst_n_i) begin
         mask_r <= 3'h7;
         wait_r <= 2'h0;
         busy_r <= 1'b0;
         ack_level_o <= 3'h0;
         handler_r <= 10'h000;
      end else begin
         mask_r <= ipm_i;
         if (busy_r) begin
            if (vector_valid_i) begin
               busy_r <= 1'b0;
               handler_r <= bus_err_i ? {8'h18, 2'b00} : {vector_i, 2'b00};
            end
         end else if (take) begin
            wait_r <= wait_r + 2'h1;
            if (wait_r == stall_i) begin
               vector_fetch_cycle_o <= 1'b1;
               ack_level_o <= level_i;
               busy_r <= 1'b1;
               wait_r <= 2'h0;
            end
         end
      end
   end
endmodule : lvic_cpu_model
`default_nettype wire

/* tb/lvic_ctrl_assertions.sv */
// Port-level checks of the interrupt controller
`default_nettype none
module lvic_ctrl_assertions (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic brkpt_req_i,
   input wire logic vector_fetch_cycle_i,
   input wire logic [2:0] ack_level_i,
   input wire logic [2:0] level_o,
   input wire logic [7:0] vector_o,
   input wire logic vector_valid_o
);
   logic base_set_r;
   logic [4:0] base_r;
   logic [22:0] mask_r;
   // Shadow of base and mask
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         base_set_r <= 1'b0;
         base_r <= lvic_pkg::VEC_BASE_RST;
         mask_r <= lvic_pkg::MASK_RST;
      end else if (reg_wr_i && reg_addr_i == lvic_pkg::OFS_VECTOR_BASE) begin
         base_set_r <= 1'b1;
         base_r <= reg_wdata_i[7:3];
      end else if (reg_wr_i && reg_addr_i == lvic_pkg::OFS_MASK) begin
         mask_r <= reg_wdata_i[22:0];
      end
   end
   ////////////////////////////////////////
   default clocking dcb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_fetch_answered: assert property (vector_fetch_cycle_i |=> vector_valid_o)
      else $error("acknowledge not answered");
   a_valid_has_cause: assert property (rst_n_i && !vector_fetch_cycle_i |=> !vector_valid_o)
      else $error("vector valid without acknowledge");
   a_vector_holds: assert property (rst_n_i && !vector_fetch_cycle_i |=> $stable(vector_o))
      else $error("vector changed without acknowledge");
   a_uninit_vector: assert property (vector_fetch_cycle_i && !base_set_r |=> vector_o == 8'h0F)
      else $error("uninitialised vector wrong");
   a_vector_base: assert property (vector_fetch_cycle_i && base_set_r |=> vector_o[7:3] == $past(base_r))
      else $error("vector base bits wrong");
   a_vector_level: assert property (vector_fetch_cycle_i && base_set_r |=> vector_o[2:0] == $past(ack_level_i))
      else $error("vector level bits wrong");
   a_all_masked: assert property ((mask_r == 23'h7FFFFF) [*2] |-> level_o == 3'h0)
      else $error("level shown while all masked");
   a_break_top: assert property ((brkpt_req_i && !mask_r[1]) [*3] |=> level_o == 3'h7)
      else $error("breakpoint not at top level");
   a_read_idle: assert property (rst_n_i && !reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not zero when idle");
endmodule : lvic_ctrl_assertions
bind lvic_ctrl lvic_ctrl_assertions chk_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .brkpt_req_i(brkpt_req_i), .vector_fetch_cycle_i(vector_fetch_cycle_i),
   .ack_level_i(ack_level_i), .level_o(level_o), .vector_o(vector_o), .vector_valid_o(vector_valid_o));
`default_nettype wire

/* tb/test_leveled_vector_interrupt_ctrl.sv */
// Self-checking bench of the interrupt controller
`default_nettype none
module test_leveled_vector_interrupt_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [5:0] pin = 6'h3F;
   logic [3:0] gp = 4'hF;
   logic [12:0] irq = 13'h0000;
   logic [2:0] ipm = 3'h7;
   logic [1:0] stall = 2'h0;
   logic berr = 1'b0;
   logic [31:0] rdata;
   logic fetch;
   logic [2:0] ack_lvl;
   logic [2:0] level;
   logic [7:0] vector;
   logic valid;
   int n_fail = 0;
   int comparisons = 0;
   lvic_ctrl dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .emulation_request_in_n_i(pin[5]),
      .ext_request_six_i(pin[4]), .pen_request_in_i(pin[3]), .ext_request_three_i(pin[2]),
      .ext_request_two_i(pin[1]), .ext_request_one_i(pin[0]), .gp_request_i(gp), .brkpt_req_i(irq[0]),
      .tmr1_req_i(irq[1]), .pwm1_req_i(irq[2]), .tmr2_req_i(irq[3]), .pwm2_req_i(irq[4]),
      .spi1_req_i(irq[5]), .uart2_req_i(irq[6]), .spi2_req_i(irq[7]), .uart1_req_i(irq[8]),
      .wdt_req_i(irq[9]), .rtc_req_i(irq[10]), .rti_req_i(irq[11]), .kbd_req_i(irq[12]),
      .vector_fetch_cycle_i(fetch), .ack_level_i(ack_lvl), .level_o(level), .vector_o(vector),
      .vector_valid_o(valid));
   lvic_cpu_model cpu_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .level_i(level), .ipm_i(ipm),
      .stall_i(stall), .bus_err_i(berr), .vector_i(vector), .vector_valid_i(valid), .vector_fetch_cycle_o(fetch),
      .ack_level_o(ack_lvl));
   ////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk_i);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge sys_clk_i);
      rd_s <= 1'b0;
      @(negedge sys_clk_i);
      chk("read data", rdata, exp);
   endtask : rd
   task automatic lvl(input logic [2:0] exp);
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("level", {29'h0, level}, {29'h0, exp});
      @(posedge sys_clk_i);
   endtask : lvl
   task automatic vec(input logic [7:0] exp);
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      for (int i = 0; i < 30 && valid !== 1'b1; i++) begin
         @(negedge sys_clk_i);
      end
      chk("vector valid", {31'h0, valid}, 32'h00000001);
      chk("vector", {24'h0, vector}, {24'h0, exp});
      @(posedge sys_clk_i);
   endtask : vec
   task automatic t_reset();
      rd(lvic_pkg::OFS_MASK, 32'h007FFFFF);
      rd(lvic_pkg::OFS_PROG_LEVEL, 32'h00000DB6);
      rd(lvic_pkg::OFS_PIN_TRIGGER, 32'h0);
      rd(4'h9, 32'h0);
      lvl(3'h0);
   endtask : t_reset
   task automatic t_vectors();
      wr(lvic_pkg::OFS_MASK, 32'h007FFFF7);
      irq <= 13'h0002;
      lvl(3'h6);
      ipm <= 3'h0;
      vec(8'h0F);
      ipm <= 3'h7;
      stall <= 2'h3;
      repeat (4) @(posedge sys_clk_i);
      wr(lvic_pkg::OFS_VECTOR_BASE, 32'h00000040);
      ipm <= 3'h0;
      vec(8'h46);
      lvl(3'h6);
      chk("handler", {22'h0, cpu_u.handler_r}, 32'h00000118);
      berr <= 1'b1;
      vec(8'h46);
      lvl(3'h6);
      chk("handler", {22'h0, cpu_u.handler_r}, 32'h00000060);
      berr <= 1'b0;
   endtask : t_vectors
   task automatic t_prio();
      wr(lvic_pkg::OFS_MASK, 32'h0);
      irq <= 13'h1001;
      lvl(3'h7);
      vec(8'h47);
      irq <= 13'h1000;
      lvl(3'h4);
      wr(lvic_pkg::OFS_MASK, 32'h2);
      irq <= 13'h0001;
      lvl(3'h0);
      rd(lvic_pkg::OFS_PENDING, 32'h2);
      rd(lvic_pkg::OFS_REQ_STATUS, 32'h0);
      wr(lvic_pkg::OFS_MASK, 32'h0);
   endtask : t_prio
   task automatic t_sources();
      logic [2:0] lv [2][13] = '{'{3'h7, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4},
         '{3'h7, 3'h6, 3'h6, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4}};
      for (int j = 0; j < 2; j++) begin
         if (j == 1) begin
            wr(lvic_pkg::OFS_PROG_LEVEL, 32'h00000AD1);
         end
         for (int i = 0; i < 13; i++) begin
            irq <= 13'h0001 << i;
            lvl(lv[j][i]);
         end
      end
      irq <= 13'h0000;
   endtask : t_sources
   task automatic t_pins();
      logic [2:0] lp [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
      for (int i = 0; i < 6; i++) begin
         pin <= ~(6'h01 << i);
         lvl(lp[i]);
      end
      pin <= 6'h3F;
      gp <= 4'hE;
      lvl(3'h4);
      gp <= 4'hF;
      wr(lvic_pkg::OFS_PIN_TRIGGER, 32'h00000200);
      pin <= 6'h3B;
      lvl(3'h3);
      pin <= 6'h3F;
      lvl(3'h3);
      rd(lvic_pkg::OFS_PENDING, 32'h00100000);
      wr(lvic_pkg::OFS_REQ_STATUS, 32'h00100000);
      lvl(3'h0);
      wr(lvic_pkg::OFS_PIN_TRIGGER, 32'h00002000);
      lvl(3'h3);
      wr(lvic_pkg::OFS_GP_TRIGGER, 32'h00000002);
      gp <= 4'hD;
      lvl(3'h4);
      gp <= 4'hF;
      lvl(3'h4);
      wr(lvic_pkg::OFS_REQ_STATUS, 32'h00020000);
      lvl(3'h3);
   endtask : t_pins
   task automatic final_report();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_vectors();
      t_prio();
      t_sources();
      t_pins();
      final_report();
   end
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      n_fail++;
      final_report();
   end
endmodule : test_leveled_vector_interrupt_ctrl
`default_nettype wire
